/* File: hw/mlsr_pkg.sv */
// -----------------------------------------------------------------
// Link setup resolve: shared constants and types
// -----------------------------------------------------------------
package mlsr_pkg;

    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] EXT_CTRL_OFS = 8'h18;

    // Control register field positions
    localparam int CTRL_DUPLEX_BIT = 0;
    localparam int CTRL_LINKUP_BIT = 6;
    localparam int CTRL_SPEED_LSB = 8;
    localparam int CTRL_FRC_SPEED_BIT = 11;
    localparam int CTRL_FRC_DUPLEX_BIT = 12;
    localparam int CTRL_RX_PAUSE_BIT = 27;
    localparam int CTRL_TX_PAUSE_BIT = 28;

    // Status register field positions
    localparam int STAT_DUPLEX_BIT = 0;
    localparam int STAT_LINKUP_BIT = 1;
    localparam int STAT_PHY_UP_BIT = 2;
    localparam int STAT_SPEED_LSB = 6;

    // Extended control field positions
    localparam int EXT_INV_LOS_BIT = 7;
    localparam int EXT_IF_SEL_LSB = 22;

    // Speed encodings
    typedef enum logic [1:0] {
        MLSR_SPD_10 = 2'b00,
        MLSR_SPD_100 = 2'b01,
        MLSR_SPD_1000 = 2'b10,
        MLSR_SPD_RSVD = 2'b11
    } mlsr_speed_t;

    // Interface attachment modes
    typedef enum logic [1:0] {
        MLSR_IF_MAC_PHY = 2'b00,
        MLSR_IF_ALT_1 = 2'b01,
        MLSR_IF_ALT_2 = 2'b10,
        MLSR_IF_ALT_3 = 2'b11
    } mlsr_if_mode_t;

    // PHY link tracking states
    typedef enum logic [0:0] {
        MLSR_LS_DOWN = 1'b0,
        MLSR_LS_UP = 1'b1
    } mlsr_link_st_t;

    // Reset values
    localparam logic RST_BIT = 1'b0;
    localparam mlsr_speed_t RST_SPEED = MLSR_SPD_10;
    localparam mlsr_if_mode_t RST_IF_SEL = MLSR_IF_MAC_PHY;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

endpackage

/* File: hw/mlsr_res_if.sv */
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------
// Carrier between register side and resolver
// -----------------------------------------------------------------
interface mlsr_res_if;
    // Software controls
    logic force_duplex_ctl;
    logic force_speed_ctl;
    logic full_duplex_ctl;
    mlsr_pkg::mlsr_speed_t speed_ctl;
    logic set_link_up_ctl;
    logic invert_loss_of_signal;
    mlsr_pkg::mlsr_if_mode_t interface_select_field;
    // PHY indications
    logic phy_link_ind;
    logic phy_duplex_ind;
    mlsr_pkg::mlsr_speed_t phy_speed_ind;
    // Held status, fed back
    logic duplex_hold;
    mlsr_pkg::mlsr_speed_t speed_hold;
    // Resolved values
    logic phy_link_eff;
    logic duplex_next;
    mlsr_pkg::mlsr_speed_t speed_next;
    logic link_up_next;

    modport ctl (
        output force_duplex_ctl, force_speed_ctl, full_duplex_ctl, speed_ctl,
        output set_link_up_ctl, invert_loss_of_signal, interface_select_field,
        output phy_link_ind, phy_duplex_ind, phy_speed_ind, duplex_hold, speed_hold,
        input phy_link_eff, duplex_next, speed_next, link_up_next
    );
    modport res (
        input force_duplex_ctl, force_speed_ctl, full_duplex_ctl, speed_ctl,
        input set_link_up_ctl, invert_loss_of_signal, interface_select_field,
        input phy_link_ind, phy_duplex_ind, phy_speed_ind, duplex_hold, speed_hold,
        output phy_link_eff, duplex_next, speed_next, link_up_next
    );
endinterface // mlsr_res_if
`default_nettype wire

/* File: hw/mlsr_resolve.sv */
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------
// Duplex, speed and link-up resolution
// -----------------------------------------------------------------
module mlsr_resolve (
    // Controls in, resolved values out
    mlsr_res_if.res rif
);

    logic mac_phy_mode;

    // Only the MAC-to-PHY attachment resolves duplex and speed from PHY indications
    assign mac_phy_mode = (rif.interface_select_field == mlsr_pkg::MLSR_IF_MAC_PHY);

    // Optional inversion of the link indication polarity
    assign rif.phy_link_eff = rif.phy_link_ind ^ rif.invert_loss_of_signal;

    // Duplex: forced value, else PHY value once link is up, else hold
    always_comb
    begin
        if (rif.force_duplex_ctl)
            rif.duplex_next = rif.full_duplex_ctl;
        else if (mac_phy_mode && rif.phy_link_eff)
            rif.duplex_next = rif.phy_duplex_ind;
        else
            rif.duplex_next = rif.duplex_hold;
    end

    // Speed: same priority; software field ignored unless forced
    always_comb
    begin
        if (rif.force_speed_ctl)
            rif.speed_next = rif.speed_ctl;
        else if (mac_phy_mode && rif.phy_link_eff)
            rif.speed_next = rif.phy_speed_ind;
        else
            rif.speed_next = rif.speed_hold;
    end

    // Link up is PHY link qualified by software, in every mode
    assign rif.link_up_next = rif.phy_link_eff & rif.set_link_up_ctl;

endmodule // mlsr_resolve
`default_nettype wire

/* File: hw/mlsr_top.sv */
`timescale 1ns/1ps
`default_nettype none
module mlsr_top (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Register port
    input wire logic [mlsr_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [mlsr_pkg::DATA_W-1:0] reg_wr_data,
    input wire logic reg_wr_stb,
    input wire logic reg_rd_stb,
    output logic [mlsr_pkg::DATA_W-1:0] reg_rd_data,
    // PHY indications
    input wire logic phy_link_ind,
    input wire logic phy_duplex_ind,
    input wire logic [1:0] phy_speed_ind,
    // Resolved MAC settings
    output logic duplex_status_bit,
    output logic link_up_status_bit,
    output logic [1:0] speed_status,
    output logic rx_pause_enable,
    output logic tx_pause_enable,
    output logic [1:0] interface_select_field
);

    // -----------------------------------------------------------------
    // Control and status storage
    // -----------------------------------------------------------------
    logic full_duplex_ctl_reg;
    logic set_link_up_ctl_reg;
    mlsr_pkg::mlsr_speed_t speed_ctl_reg;
    logic force_speed_ctl_reg;
    logic force_duplex_ctl_reg;
    logic rx_pause_enable_reg;
    logic tx_pause_enable_reg;
    logic invert_loss_of_signal_reg;
    mlsr_pkg::mlsr_if_mode_t interface_select_field_reg;
    logic duplex_status_bit_reg;
    logic link_up_status_bit_reg;
    mlsr_pkg::mlsr_speed_t speed_status_reg;
    mlsr_pkg::mlsr_link_st_t link_st_reg;
    mlsr_pkg::mlsr_link_st_t link_st_next;
    logic [mlsr_pkg::DATA_W-1:0] rd_data_reg;
    logic [mlsr_pkg::DATA_W-1:0] rd_data_next;
    logic [mlsr_pkg::DATA_W-1:0] ctrl_view;
    logic [mlsr_pkg::DATA_W-1:0] status_view;
    logic [mlsr_pkg::DATA_W-1:0] ext_view;
    logic wr_ctrl;
    logic wr_ext;

    // -----------------------------------------------------------------
    // Resolver hookup
    // -----------------------------------------------------------------
    mlsr_res_if rif ();

    // Present controls and held status to the resolver
    assign rif.force_duplex_ctl = force_duplex_ctl_reg;
    assign rif.force_speed_ctl = force_speed_ctl_reg;
    assign rif.full_duplex_ctl = full_duplex_ctl_reg;
    assign rif.speed_ctl = speed_ctl_reg;
    assign rif.set_link_up_ctl = set_link_up_ctl_reg;
    assign rif.invert_loss_of_signal = invert_loss_of_signal_reg;
    assign rif.interface_select_field = interface_select_field_reg;
    assign rif.phy_link_ind = phy_link_ind;
    assign rif.phy_duplex_ind = phy_duplex_ind;
    assign rif.phy_speed_ind = mlsr_pkg::mlsr_speed_t'(phy_speed_ind);
    assign rif.duplex_hold = duplex_status_bit_reg;
    assign rif.speed_hold = speed_status_reg;

    mlsr_resolve u_resolve (
        .rif (rif)
    );

    // -----------------------------------------------------------------
    // Write decode
    // -----------------------------------------------------------------
    // Status is read only; writes to it or unmapped offsets are dropped
    always_comb
    begin
        wr_ctrl = 1'b0;
        wr_ext = 1'b0;
        if (!reg_wr_stb)
        begin
            wr_ctrl = 1'b0;
        end
        else if (reg_addr == mlsr_pkg::CTRL_OFS)
        begin
            wr_ctrl = 1'b1;
        end
        else if (reg_addr == mlsr_pkg::EXT_CTRL_OFS)
        begin
            wr_ext = 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // Control register: duplex, link enable, speed, force bits
    // -----------------------------------------------------------------
    // Software values are stored regardless of mode; resolver decides use
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            full_duplex_ctl_reg <= mlsr_pkg::RST_BIT;
            set_link_up_ctl_reg <= mlsr_pkg::RST_BIT;
            speed_ctl_reg <= mlsr_pkg::RST_SPEED;
            force_speed_ctl_reg <= mlsr_pkg::RST_BIT;
            force_duplex_ctl_reg <= mlsr_pkg::RST_BIT;
        end
        else if (clk_en && wr_ctrl)
        begin
            full_duplex_ctl_reg <= reg_wr_data[mlsr_pkg::CTRL_DUPLEX_BIT];
            set_link_up_ctl_reg <= reg_wr_data[mlsr_pkg::CTRL_LINKUP_BIT];
            speed_ctl_reg <= mlsr_pkg::mlsr_speed_t'(reg_wr_data[mlsr_pkg::CTRL_SPEED_LSB +: 2]);
            force_speed_ctl_reg <= reg_wr_data[mlsr_pkg::CTRL_FRC_SPEED_BIT];
            force_duplex_ctl_reg <= reg_wr_data[mlsr_pkg::CTRL_FRC_DUPLEX_BIT];
        end
    end

    // -----------------------------------------------------------------
    // Control register: pause enables
    // -----------------------------------------------------------------
    // Hardware never alters these; software owns the flow-control choice
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rx_pause_enable_reg <= mlsr_pkg::RST_BIT;
            tx_pause_enable_reg <= mlsr_pkg::RST_BIT;
        end
        else if (clk_en && wr_ctrl)
        begin
            rx_pause_enable_reg <= reg_wr_data[mlsr_pkg::CTRL_RX_PAUSE_BIT];
            tx_pause_enable_reg <= reg_wr_data[mlsr_pkg::CTRL_TX_PAUSE_BIT];
        end
    end

    // -----------------------------------------------------------------
    // Extended control: interface select, loss-of-signal inversion
    // -----------------------------------------------------------------
    // Only MAC-to-PHY resolves from the PHY; others hold last duplex and speed unless forced
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            interface_select_field_reg <= mlsr_pkg::RST_IF_SEL;
            invert_loss_of_signal_reg <= mlsr_pkg::RST_BIT;
        end
        else if (clk_en && wr_ext)
        begin
            interface_select_field_reg <=
                mlsr_pkg::mlsr_if_mode_t'(reg_wr_data[mlsr_pkg::EXT_IF_SEL_LSB +: 2]);
            invert_loss_of_signal_reg <= reg_wr_data[mlsr_pkg::EXT_INV_LOS_BIT];
        end
    end

    // -----------------------------------------------------------------
    // PHY link tracking
    // -----------------------------------------------------------------
    // Marks when the PHY reports a resolved link, shown in status
    always_comb
    begin
        link_st_next = link_st_reg;
        case (link_st_reg)
            mlsr_pkg::MLSR_LS_DOWN:
            begin
                if (rif.phy_link_eff)
                    link_st_next = mlsr_pkg::MLSR_LS_UP;
            end
            mlsr_pkg::MLSR_LS_UP:
            begin
                if (!rif.phy_link_eff)
                    link_st_next = mlsr_pkg::MLSR_LS_DOWN;
            end
            default:
            begin
                link_st_next = mlsr_pkg::MLSR_LS_DOWN;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            link_st_reg <= mlsr_pkg::MLSR_LS_DOWN;
        else if (clk_en)
            link_st_reg <= link_st_next;
    end

    // -----------------------------------------------------------------
    // Resolved status
    // -----------------------------------------------------------------
    // One cycle behind inputs; PHY values only taken while link is up
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            duplex_status_bit_reg <= mlsr_pkg::RST_BIT;
            speed_status_reg <= mlsr_pkg::RST_SPEED;
        end
        else if (clk_en)
        begin
            duplex_status_bit_reg <= rif.duplex_next;
            speed_status_reg <= rif.speed_next;
        end
    end

    // Link-up qualified by software enable in every mode
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            link_up_status_bit_reg <= mlsr_pkg::RST_BIT;
        else if (clk_en)
            link_up_status_bit_reg <= rif.link_up_next;
    end

    // -----------------------------------------------------------------
    // Read path
    // -----------------------------------------------------------------
    // Register images; reserved bits read zero
    always_comb
    begin
        ctrl_view = mlsr_pkg::RD_ZERO;
        ctrl_view[mlsr_pkg::CTRL_DUPLEX_BIT] = full_duplex_ctl_reg;
        ctrl_view[mlsr_pkg::CTRL_LINKUP_BIT] = set_link_up_ctl_reg;
        ctrl_view[mlsr_pkg::CTRL_SPEED_LSB +: 2] = speed_ctl_reg;
        ctrl_view[mlsr_pkg::CTRL_FRC_SPEED_BIT] = force_speed_ctl_reg;
        ctrl_view[mlsr_pkg::CTRL_FRC_DUPLEX_BIT] = force_duplex_ctl_reg;
        ctrl_view[mlsr_pkg::CTRL_RX_PAUSE_BIT] = rx_pause_enable_reg;
        ctrl_view[mlsr_pkg::CTRL_TX_PAUSE_BIT] = tx_pause_enable_reg;
    end

    always_comb
    begin
        status_view = mlsr_pkg::RD_ZERO;
        status_view[mlsr_pkg::STAT_DUPLEX_BIT] = duplex_status_bit_reg;
        status_view[mlsr_pkg::STAT_LINKUP_BIT] = link_up_status_bit_reg;
        status_view[mlsr_pkg::STAT_PHY_UP_BIT] = (link_st_reg == mlsr_pkg::MLSR_LS_UP);
        status_view[mlsr_pkg::STAT_SPEED_LSB +: 2] = speed_status_reg;
    end

    always_comb
    begin
        ext_view = mlsr_pkg::RD_ZERO;
        ext_view[mlsr_pkg::EXT_INV_LOS_BIT] = invert_loss_of_signal_reg;
        ext_view[mlsr_pkg::EXT_IF_SEL_LSB +: 2] = interface_select_field_reg;
    end

    // Read decode; unmapped offsets return zero
    always_comb
    begin
        rd_data_next = mlsr_pkg::RD_ZERO;
        if (!reg_rd_stb)
            rd_data_next = mlsr_pkg::RD_ZERO;
        else if (reg_addr == mlsr_pkg::CTRL_OFS)
            rd_data_next = ctrl_view;
        else if (reg_addr == mlsr_pkg::STATUS_OFS)
            rd_data_next = status_view;
        else if (reg_addr == mlsr_pkg::EXT_CTRL_OFS)
            rd_data_next = ext_view;
    end

    // Data stand in the cycle after a strobe taken with clk_en, zero otherwise; the word holds while clk_en is low
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            rd_data_reg <= mlsr_pkg::RD_ZERO;
        else if (clk_en)
            rd_data_reg <= rd_data_next;
    end

    // -----------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // -----------------------------------------------------------------
    assign reg_rd_data = rd_data_reg;
    assign duplex_status_bit = duplex_status_bit_reg;
    assign link_up_status_bit = link_up_status_bit_reg;
    assign speed_status = speed_status_reg;
    assign rx_pause_enable = rx_pause_enable_reg;
    assign tx_pause_enable = tx_pause_enable_reg;
    assign interface_select_field = interface_select_field_reg;

endmodule // mlsr_top
`default_nettype wire

/* File: test/mlsr_phy_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// PHY indication model
// ------------------------------
module mlsr_phy_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Bench requests
    input wire logic neg_en,
    input wire logic force_link,
    input wire logic want_duplex,
    input wire logic [1:0] want_speed,
    input wire logic [7:0] neg_cycles,
    // Indications to the MAC
    output logic phy_link_ind,
    output logic phy_duplex_ind,
    output logic [1:0] phy_speed_ind
);
    logic [7:0] cnt_reg;
    logic done;
    // Forced PHY shows link at once, else after the count
    assign done = neg_en && (force_link || cnt_reg == neg_cycles);
    // Duplex and speed churn without link: nothing is promised then
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            cnt_reg <= 8'h0;
            phy_link_ind <= 1'b0;
            phy_duplex_ind <= 1'b0;
            phy_speed_ind <= 2'h0;
        end
        else
        begin
            cnt_reg <= done ? cnt_reg : (neg_en ? cnt_reg + 8'h1 : 8'h0);
            phy_link_ind <= done;
            phy_duplex_ind <= done ? want_duplex : !phy_duplex_ind;
            phy_speed_ind <= done ? want_speed : phy_speed_ind + 2'h1;
        end
    end
endmodule // mlsr_phy_model
`default_nettype wire

/* File: test/mlsr_chk_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Link resolve checker
// ------------------------------
module mlsr_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wr_data,
    input wire logic reg_wr_stb,
    input wire logic reg_rd_stb,
    input wire logic [31:0] reg_rd_data,
    // PHY indications
    input wire logic phy_link_ind,
    input wire logic phy_duplex_ind,
    input wire logic [1:0] phy_speed_ind,
    // Resolved outputs
    input wire logic duplex_status_bit,
    input wire logic link_up_status_bit,
    input wire logic [1:0] speed_status,
    input wire logic rx_pause_enable,
    input wire logic tx_pause_enable,
    input wire logic [1:0] interface_select_field
);
    logic [31:0] ctl_reg;
    logic [31:0] ext_reg;
    logic live_reg;
    logic eff_link;
    logic phy_path;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Shadow of software writes, frozen with clk_en like the block
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctl_reg <= 32'h0;
            ext_reg <= 32'h0;
        end
        else if (clk_en && reg_wr_stb && reg_addr == mlsr_pkg::CTRL_OFS)
            ctl_reg <= reg_wr_data;
        else if (clk_en && reg_wr_stb && reg_addr == mlsr_pkg::EXT_CTRL_OFS)
            ext_reg <= reg_wr_data;
    end
    // Checks wait one clean edge; status is stale after reset or a frozen edge
    always_ff @(posedge sys_clk)
        live_reg <= !rst && clk_en;
    // Effective link and whether PHY values may be taken
    assign eff_link = phy_link_ind ^ ext_reg[mlsr_pkg::EXT_INV_LOS_BIT];
    assign phy_path = eff_link && ext_reg[mlsr_pkg::EXT_IF_SEL_LSB +: 2] == 2'h0;
    // ------------------------------
    // Status relations
    // ------------------------------
    link_up_a: assert property (
        live_reg |-> link_up_status_bit == ($past(eff_link) && $past(ctl_reg[mlsr_pkg::CTRL_LINKUP_BIT])))
        else $error("link up wrong");
    dup_force_a: assert property (
        live_reg && $past(ctl_reg[12]) |-> duplex_status_bit == $past(ctl_reg[mlsr_pkg::CTRL_DUPLEX_BIT]))
        else $error("forced duplex wrong");
    spd_force_a: assert property (
        live_reg && $past(ctl_reg[11]) |-> speed_status == $past(ctl_reg[mlsr_pkg::CTRL_SPEED_LSB +: 2]))
        else $error("forced speed wrong");
    dup_phy_a: assert property (
        live_reg && !$past(ctl_reg[12]) && $past(phy_path) |-> duplex_status_bit == $past(phy_duplex_ind))
        else $error("PHY duplex not taken");
    spd_phy_a: assert property (
        live_reg && !$past(ctl_reg[11]) && $past(phy_path) |-> speed_status == $past(phy_speed_ind))
        else $error("PHY speed not taken");
    dup_hold_a: assert property (
        live_reg && !$past(ctl_reg[12]) && !$past(phy_path) |-> $stable(duplex_status_bit))
        else $error("duplex moved without link");
    spd_hold_a: assert property (
        live_reg && !$past(ctl_reg[11]) && !$past(phy_path) |-> $stable(speed_status))
        else $error("speed moved without link");
endmodule // mlsr_chk
`default_nettype wire

/* File: test/mlsr_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module mlsr_top_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wr_data = 32'h0;
    logic reg_wr_stb = 1'b0;
    logic reg_rd_stb = 1'b0;
    logic [31:0] reg_rd_data;
    logic phy_link_ind, phy_duplex_ind, duplex_status_bit, link_up_status_bit, rx_pause_enable, tx_pause_enable;
    logic [1:0] phy_speed_ind, speed_status, interface_select_field, sp;
    logic neg_en = 1'b0;
    logic force_link = 1'b0;
    logic want_duplex = 1'b0;
    logic [1:0] want_speed = 2'h0;
    logic [7:0] neg_cycles = 8'h8;
    logic d;
    int failures = 0;
    int n_compared = 0;
    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;
    mlsr_top dut (.sys_clk, .rst, .clk_en, .reg_addr, .reg_wr_data, .reg_wr_stb, .reg_rd_stb, .reg_rd_data,
        .phy_link_ind, .phy_duplex_ind, .phy_speed_ind, .duplex_status_bit, .link_up_status_bit,
        .speed_status, .rx_pause_enable, .tx_pause_enable, .interface_select_field);
    mlsr_phy_model phy (.sys_clk, .rst, .neg_en, .force_link, .want_duplex, .want_speed, .neg_cycles,
        .phy_link_ind, .phy_duplex_ind, .phy_speed_ind);
    // ------------------------------
    // Helpers
    // ------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            failures++;
        end
    endtask
    task automatic close_out;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_wr_stb <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= v;
        @(posedge sys_clk);
        reg_wr_stb <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        @(posedge sys_clk);
        reg_rd_stb <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd_stb <= 1'b0;
        @(negedge sys_clk);
        chk(nm, exp, reg_rd_data);
    endtask
    function automatic logic [31:0] ctl_w(logic dup, logic lnk, logic [1:0] s, logic frs, logic frd, logic [1:0] p);
        ctl_w = 32'h0;
        ctl_w[mlsr_pkg::CTRL_DUPLEX_BIT] = dup;
        ctl_w[mlsr_pkg::CTRL_LINKUP_BIT] = lnk;
        ctl_w[mlsr_pkg::CTRL_SPEED_LSB +: 2] = s;
        ctl_w[mlsr_pkg::CTRL_FRC_SPEED_BIT] = frs;
        ctl_w[mlsr_pkg::CTRL_FRC_DUPLEX_BIT] = frd;
        ctl_w[mlsr_pkg::CTRL_RX_PAUSE_BIT] = p[0];
        ctl_w[mlsr_pkg::CTRL_TX_PAUSE_BIT] = p[1];
    endfunction
    // Settle, then compare outputs and the status word
    task automatic st(input logic dx, input logic lk, input logic pl, input logic [1:0] s);
        logic [31:0] img;
        img = 32'h0;
        img[mlsr_pkg::STAT_DUPLEX_BIT] = dx;
        img[mlsr_pkg::STAT_LINKUP_BIT] = lk;
        img[mlsr_pkg::STAT_PHY_UP_BIT] = pl;
        img[mlsr_pkg::STAT_SPEED_LSB +: 2] = s;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("status outs", 32'({dx, lk, s}), 32'({duplex_status_bit, link_up_status_bit, speed_status}));
        rd(mlsr_pkg::STATUS_OFS, img, "status reg");
    endtask
    task automatic outs_zero;
        @(negedge sys_clk);
        chk("outputs", 32'h0, 32'({duplex_status_bit, link_up_status_bit, speed_status, rx_pause_enable,
            tx_pause_enable, interface_select_field}));
    endtask
    // Bounded wait for link up
    task automatic wait_link;
        int i;
        // Look mid-cycle, away from the edge that launches the status
        for (i = 0; i < 400 && link_up_status_bit !== 1'b1; i++)
            @(negedge sys_clk);
        if (i == 400)
        begin
            chk("link wait", 32'h1, 32'h0);
            close_out();
        end
    endtask
    // ------------------------------
    // Main sequence
    // ------------------------------
    initial
    begin
        sp = 2'($urandom(32'h4c60ab93));
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        outs_zero();
        rd(mlsr_pkg::CTRL_OFS, 32'h0, "ctrl reset");
        rd(mlsr_pkg::EXT_CTRL_OFS, 32'h0, "ext reset");
        wr(mlsr_pkg::EXT_CTRL_OFS, 32'h0);
        for (int k = 0; k < 3; k++)
        begin
            d = 1'($urandom());
            sp = 2'($urandom_range(2));
            want_duplex <= d;
            want_speed <= 2'(k);
            neg_cycles <= 8'($urandom_range(40, 4));
            wr(mlsr_pkg::CTRL_OFS, ctl_w(!d, 1'b1, 2'(~k), 1'b0, 1'b0, 2'(k)));
            neg_en <= 1'b1;
            wait_link();
            st(d, 1'b1, 1'b1, 2'(k));
            chk("pause", 32'(k), 32'({tx_pause_enable, rx_pause_enable}));
            rd(mlsr_pkg::CTRL_OFS, ctl_w(!d, 1'b1, 2'(~k), 1'b0, 1'b0, 2'(k)), "ctrl");
            wr(mlsr_pkg::CTRL_OFS, ctl_w(!d, 1'b1, sp, 1'b1, 1'b1, 2'(k)));
            st(!d, 1'b1, 1'b1, sp);
            wr(mlsr_pkg::CTRL_OFS, ctl_w(d, 1'b1, sp, 1'b0, 1'b1, 2'(k)));
            st(d, 1'b1, 1'b1, 2'(k));
            neg_en <= 1'b0;
            st(d, 1'b0, 1'b0, 2'(k));
        end
        // Fully forced link, then held values with inverted link and under MLSR_IF_ALT_1
        force_link <= 1'b1;
        neg_en <= 1'b1;
        want_duplex <= 1'b1;
        want_speed <= 2'h2;
        wr(mlsr_pkg::CTRL_OFS, ctl_w(1'b1, 1'b1, 2'h2, 1'b1, 1'b1, 2'h3));
        st(1'b1, 1'b1, 1'b1, 2'h2);
        wr(mlsr_pkg::CTRL_OFS, ctl_w(1'b1, 1'b0, 2'h2, 1'b1, 1'b1, 2'h3));
        st(1'b1, 1'b0, 1'b1, 2'h2);
        want_duplex <= 1'b0;
        want_speed <= 2'h1;
        wr(mlsr_pkg::EXT_CTRL_OFS, 32'h0000_0080);
        wr(mlsr_pkg::CTRL_OFS, ctl_w(1'b1, 1'b1, 2'h3, 1'b0, 1'b0, 2'h0));
        st(1'b1, 1'b0, 1'b0, 2'h2);
        wr(mlsr_pkg::EXT_CTRL_OFS, 32'h0040_0000);
        st(1'b1, 1'b1, 1'b1, 2'h2);
        chk("if select", 32'h1, 32'(interface_select_field));
        rd(mlsr_pkg::EXT_CTRL_OFS, 32'h0040_0000, "ext");
        wr(mlsr_pkg::EXT_CTRL_OFS, 32'h0);
        st(1'b0, 1'b1, 1'b1, 2'h1);
        // Read-only status, unmapped place, frozen clock enable
        wr(mlsr_pkg::STATUS_OFS, 32'hffff_ffff);
        st(1'b0, 1'b1, 1'b1, 2'h1);
        rd(8'h40, 32'h0, "unmapped");
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(mlsr_pkg::CTRL_OFS, 32'h0);
        clk_en <= 1'b1;
        rd(mlsr_pkg::CTRL_OFS, ctl_w(1'b1, 1'b1, 2'h3, 1'b0, 1'b0, 2'h0), "ctrl frozen");
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        outs_zero();
        rd(mlsr_pkg::CTRL_OFS, 32'h0, "ctrl after reset");
        close_out();
    end
endmodule // mlsr_top_tb
bind mlsr_top mlsr_chk chk (.sys_clk, .rst, .clk_en, .reg_addr, .reg_wr_data, .reg_wr_stb, .reg_rd_stb,
    .reg_rd_data, .phy_link_ind, .phy_duplex_ind, .phy_speed_ind, .duplex_status_bit, .link_up_status_bit,
    .speed_status, .rx_pause_enable, .tx_pause_enable, .interface_select_field);
`default_nettype wire
